// file: pkg/smr_pkg.sv
// Constants shared by the scan master status and setup register bank
package smr_pkg;

    // ------------------------------------------------------------------
    // Host port geometry and register offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 4;         // Host address width
    localparam int          DATA_W     = 16;        // Host data width
    localparam int          CNT_W      = 12;        // Buffer word count width
    localparam logic [3:0]  OFF_STATUS = 4'h3;      // interrupt_status
    localparam logic [3:0]  OFF_SETUP  = 4'h4;      // setup_control

    // ------------------------------------------------------------------
    // interrupt_status fields
    // ------------------------------------------------------------------
    localparam int           ST_SO_HALF  = 12;       // Scan-out half empty
    localparam int           ST_SO_EMPTY = 11;       // Scan-out empty
    localparam int           ST_SI_FULL  = 10;       // Scan-in full
    localparam int           ST_SI_HALF  = 9;        // Scan-in half full
    localparam int           ST_SEQ      = 8;        // Sequencer complete
    localparam int           ST_VEC_HI   = 2;        // Vector number msb
    localparam logic [15:0]  ST_RESET    = 16'h0800; // Empty flag set
    localparam logic [15:0]  ST_WR_MASK  = 16'h1F07; // Writable bits
    localparam logic [2:0]   VEC_NONE    = 3'h0;     // No vector done
    localparam logic [2:0]   VEC_MAX     = 3'h4;     // Highest legal vector

    // ------------------------------------------------------------------
    // setup_control fields
    // ------------------------------------------------------------------
    localparam int           SU_WIDTH    = 15;       // Interface width mode
    localparam int           SU_SOCTL_HI = 11;       // Scan-out control
    localparam int           SU_SOCTL_LO = 10;
    localparam int           SU_SYNC_HI  = 9;        // Sync bit length
    localparam int           SU_SYNC_LO  = 7;
    localparam int           SU_DEFVAL   = 6;        // Default scan-out value
    localparam int           SU_DEBUG    = 5;        // Debug mode
    localparam int           SU_BRIDGE   = 4;        // Bridge support
    localparam int           SU_TRST     = 3;        // Test reset
    localparam int           SU_SOFT     = 2;        // Soft reset
    localparam int           SU_LOOP_HI  = 1;        // Loop-back mode
    localparam int           SU_LOOP_LO  = 0;
    localparam logic [15:0]  SU_RESET    = 16'h0043; // Default 1, safe mode
    localparam logic [15:0]  SU_WR_MASK  = 16'h8FFB; // Stored writable bits

    // ------------------------------------------------------------------
    // Codes, thresholds and counts
    // ------------------------------------------------------------------
    localparam logic [1:0]        LOOP_SO     = 2'h1;    // Out to in
    localparam logic [1:0]        LOOP_MS     = 2'h2;    // Mode-select to in
    localparam logic [1:0]        LOOP_SAFE   = 2'h3;    // Safe mode
    localparam logic [1:0]        SOCTL_HOLD  = 2'h0;    // Hold last value
    localparam logic [1:0]        SOCTL_HIZ   = 2'h3;    // Release the line
    localparam logic [CNT_W-1:0]  HALF_WORDS  = 12'h038; // 56 long words
    localparam logic [CNT_W-1:0]  DEPTH_WORDS = 12'h800; // Buffer capacity
    localparam logic [1:0]        SOFT_RST_CYC = 2'h2;   // Soft reset length

endpackage

// file: design/smr_line_ctl.sv
// Scan line steering: loop-back, safe mode, test reset and scan-out drive
`timescale 1ns/1ps
`default_nettype none

module smr_line_ctl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  loop_mode,        // Loop-back code
    input  wire logic [1:0]  so_ctrl,          // Scan-out line control
    input  wire logic        default_val,      // Default scan-out value
    input  wire logic        trst,             // Test reset request
    input  wire logic        eng_shift,        // Engine is shifting data
    input  wire logic        eng_macro,        // Self-test or state macro
    input  wire logic        eng_scan_out,     // Engine scan-out data
    input  wire logic        eng_mode_select,  // Engine mode-select
    input  wire logic        eng_test_clock,   // Engine test clock
    input  wire logic        scan_in_pin,      // Raw scan-in pin
    output logic             scan_in_eng,      // Scan-in to the engine
    output logic             scan_out_line,
    output logic             scan_out_oe,
    output logic             scan_mode_select_line,
    output logic             scan_test_clock_line,
    output logic             test_reset_out_a_n,
    output logic             test_reset_out_b_n
);
    import smr_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchroniser and next-value decode
    // ------------------------------------------------------------------
    logic  si_meta;                       // First stage, read by si_sync only
    logic  si_sync;                       // Safe copy of the scan-in pin
    wire   safe      = (loop_mode == LOOP_SAFE);
    wire   drive_def = (so_ctrl != SOCTL_HOLD) && (so_ctrl != SOCTL_HIZ);
    wire   so_next   = eng_macro ? default_val :
                       eng_shift ? eng_scan_out :
                       drive_def ? default_val : scan_out_line;
    wire   oe_next   = !safe && (so_ctrl != SOCTL_HIZ);
    wire   ms_next   = safe ? 1'b1 : eng_mode_select;
    wire   tck_next  = safe ? 1'b0 : eng_test_clock;
    wire   rst_low   = safe || trst;
    wire   si_next   = (loop_mode == LOOP_SO) ? scan_out_line :
                       (loop_mode == LOOP_MS) ? scan_mode_select_line :
                       si_sync;

    // Two-stage synchroniser for the scan-in pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            si_meta <= 1'b0;
            si_sync <= 1'b0;
        end else begin
            si_meta <= scan_in_pin;
            si_sync <= si_meta;
        end
    end

    // Registered line outputs; reset leaves the lines in safe mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_in_eng           <= 1'b0;
            scan_out_line         <= 1'b1;
            scan_out_oe           <= 1'b0;
            scan_mode_select_line <= 1'b1;
            scan_test_clock_line  <= 1'b0;
            test_reset_out_a_n    <= 1'b0;
            test_reset_out_b_n    <= 1'b0;
        end else begin
            scan_in_eng           <= si_next;
            scan_out_line         <= so_next;
            scan_out_oe           <= oe_next;
            scan_mode_select_line <= ms_next;
            scan_test_clock_line  <= tck_next;
            test_reset_out_a_n    <= !rst_low;
            test_reset_out_b_n    <= !rst_low;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SAFE_LINES: assert property (
        safe |=> scan_mode_select_line && !scan_test_clock_line
                 && !scan_out_oe && !test_reset_out_a_n)
        else $error("safe mode lines wrong");

    AST_TRST_BOTH: assert property (
        (trst || safe) |=> !test_reset_out_a_n && !test_reset_out_b_n)
        else $error("test reset outputs not low");

    AST_TRST_RELEASE: assert property (
        (!trst && !safe) |=> test_reset_out_a_n && test_reset_out_b_n)
        else $error("test reset outputs not released");

    AST_SO_HOLD: assert property (
        (!eng_macro && !eng_shift && so_ctrl == SOCTL_HOLD)
        |=> $stable(scan_out_line))
        else $error("scan-out not held");

    AST_SO_DEFAULT: assert property (
        eng_macro |=> scan_out_line == $past(default_val))
        else $error("macro does not drive default value");

endmodule

`default_nettype wire

// file: design/smr_regs.sv
// Status and setup register bank of the scan test master, host side
`timescale 1ns/1ps
`default_nettype none

module smr_regs (
    input  wire logic                        SYS_CLK,
    input  wire logic                        ARST_N,
    input  wire logic                        HOST_CS_N,
    input  wire logic                        HOST_RD_N,
    input  wire logic                        HOST_WR_N,
    input  wire logic [smr_pkg::ADDR_W-1:0]  HOST_ADDR,
    input  wire logic [smr_pkg::DATA_W-1:0]  HOST_DATA_IN,
    output logic      [smr_pkg::DATA_W-1:0]  HOST_DATA_OUT,
    output logic                             HOST_DATA_OE,
    input  wire logic [smr_pkg::DATA_W-1:0]  INT_ENABLE,
    input  wire logic [smr_pkg::CNT_W-1:0]   SO_WORD_COUNT,
    input  wire logic [smr_pkg::CNT_W-1:0]   SI_WORD_COUNT,
    input  wire logic                        SEQ_START,
    input  wire logic                        SEQ_DONE,
    input  wire logic                        VEC_DONE,
    input  wire logic [2:0]                  VEC_NUM,
    input  wire logic                        ENG_SHIFT,
    input  wire logic                        ENG_MACRO,
    input  wire logic                        ENG_SCAN_OUT,
    input  wire logic                        ENG_MODE_SELECT,
    input  wire logic                        ENG_TEST_CLOCK,
    input  wire logic                        SCAN_IN_LINE,
    output logic                             IRQ,
    output logic                             WIDTH_MODE,
    output logic      [2:0]                  SYNC_BIT_LENGTH,
    output logic                             BRIDGE_SUPPORT,
    output logic                             DEBUG_MODE,
    output logic                             SSI_RESET,
    output logic                             SCAN_IN_TO_ENGINE,
    output logic                             SCAN_OUT_LINE,
    output logic                             SCAN_OUT_LINE_OE,
    output logic                             SCAN_MODE_SELECT_LINE,
    output logic                             SCAN_TEST_CLOCK_LINE,
    output logic                             TEST_RESET_OUT_A_N,
    output logic                             TEST_RESET_OUT_B_N
);
    import smr_pkg::*;

    localparam int PIN_W = 3 + ADDR_W + DATA_W;  // Host pins synchronised

    // Address match, used for both read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // Reset release and host pin synchronisers
    // ------------------------------------------------------------------
    logic              rst_meta;                 // Reset release stage 1
    logic              rst_n;                    // Released reset copy
    logic [PIN_W-1:0]  pin_meta;                 // Pin stage 1
    logic [PIN_W-1:0]  pin_sync;                 // Pin stage 2
    logic              wr_prev_reg;              // Write strobe last cycle

    // Reset released through two flip-flops
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Host pins pass two flip-flops before any decode
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= {3'h7, {(ADDR_W+DATA_W){1'b0}}};
            pin_sync <= {3'h7, {(ADDR_W+DATA_W){1'b0}}};
        end else begin
            pin_meta <= {HOST_CS_N, HOST_RD_N, HOST_WR_N,
                         HOST_ADDR, HOST_DATA_IN};
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------------
    wire              cs_s      = !pin_sync[PIN_W-1];
    wire              rd_s      = !pin_sync[PIN_W-2];
    wire              wr_s      = !pin_sync[PIN_W-3];
    wire [ADDR_W-1:0] addr_s    = pin_sync[DATA_W +: ADDR_W];
    wire [DATA_W-1:0] wdata     = pin_sync[DATA_W-1:0];
    wire              wr_act    = cs_s && wr_s;
    wire              wr_take   = wr_act && !wr_prev_reg;  // Once per strobe
    wire              rd_act    = cs_s && rd_s;
    wire              wr_status = wr_take && hit(addr_s, OFF_STATUS);
    wire              wr_setup  = wr_take && hit(addr_s, OFF_SETUP);

    // ------------------------------------------------------------------
    // Registers and hardware status decode
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] status_reg;     // interrupt_status contents
    logic [DATA_W-1:0] setup_reg;      // setup_control, soft bit held apart
    logic [1:0]        soft_cnt_reg;   // Soft reset cycles left

    wire        debug    = setup_reg[SU_DEBUG];
    wire [2:0]  vec_cur  = status_reg[ST_VEC_HI:0];
    wire        so_empty = (SO_WORD_COUNT == {CNT_W{1'b0}});
    wire        so_half  = (SO_WORD_COUNT <= HALF_WORDS);
    wire        si_full  = (SI_WORD_COUNT >= DEPTH_WORDS);
    wire        si_half  = (SI_WORD_COUNT >= HALF_WORDS);
    // Sequencer flag: done sets, start clears, set wins
    wire        seq_hw   = SEQ_DONE || (status_reg[ST_SEQ] && !SEQ_START);
    wire        vec_ok   = VEC_DONE && (VEC_NUM != VEC_NONE)
                           && (VEC_NUM <= VEC_MAX);
    wire        vec_lock = SEQ_DONE || status_reg[ST_SEQ];
    wire [2:0]  vec_hw   = vec_lock  ? vec_cur :
                           vec_ok    ? VEC_NUM :
                           SEQ_START ? VEC_NONE : vec_cur;
    wire [DATA_W-1:0] status_hw = {3'h0, so_half, so_empty, si_full,
                                   si_half, seq_hw, 5'h00, vec_hw};
    // Debug freezes hardware updates and opens the register to writes
    wire [DATA_W-1:0] status_next =
        !debug    ? status_hw :
        wr_status ? (wdata & ST_WR_MASK) : status_reg;
    wire [DATA_W-1:0] setup_next =
        wr_setup ? (wdata & SU_WR_MASK) : setup_reg;
    wire [1:0]  soft_next =
        (wr_setup && wdata[SU_SOFT]) ? SOFT_RST_CYC :
        (soft_cnt_reg != 2'h0) ? soft_cnt_reg - 2'h1 : 2'h0;
    wire        ssi_rst_next = (soft_next != 2'h0)
                               || setup_next[SU_TRST];
    wire [DATA_W-1:0] setup_rd = setup_reg
        | {{(DATA_W-SU_SOFT-1){1'b0}}, (soft_cnt_reg != 2'h0),
           {SU_SOFT{1'b0}}};
    wire [DATA_W-1:0] rdata =
        hit(addr_s, OFF_STATUS) ? status_reg :
        hit(addr_s, OFF_SETUP)  ? setup_rd : {DATA_W{1'b0}};
    wire        vec_irq  = (vec_cur != VEC_NONE)
                           && (vec_cur == INT_ENABLE[ST_VEC_HI:0]);
    wire        irq_next = |(status_reg[ST_SO_HALF:ST_SEQ]
                             & INT_ENABLE[ST_SO_HALF:ST_SEQ])
                           || vec_irq;

    // Register state
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_reg  <= 1'b0;
            status_reg   <= ST_RESET;
            setup_reg    <= SU_RESET;
            soft_cnt_reg <= 2'h0;
        end else begin
            wr_prev_reg  <= wr_act;
            status_reg   <= status_next;
            setup_reg    <= setup_next;
            soft_cnt_reg <= soft_next;
        end
    end

    // Registered host outputs, reset and interrupt
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            HOST_DATA_OUT <= {DATA_W{1'b0}};
            HOST_DATA_OE  <= 1'b0;
            IRQ           <= 1'b0;
            SSI_RESET     <= 1'b0;
        end else begin
            HOST_DATA_OUT <= rd_act ? rdata : {DATA_W{1'b0}};
            HOST_DATA_OE  <= rd_act;
            IRQ           <= irq_next;
            SSI_RESET     <= ssi_rst_next;
        end
    end

    // Setup fields straight from the register
    assign WIDTH_MODE      = setup_reg[SU_WIDTH];
    assign SYNC_BIT_LENGTH = setup_reg[SU_SYNC_HI:SU_SYNC_LO];
    assign BRIDGE_SUPPORT  = setup_reg[SU_BRIDGE];
    assign DEBUG_MODE      = setup_reg[SU_DEBUG];

    // ------------------------------------------------------------------
    // Scan line steering
    // ------------------------------------------------------------------
    smr_line_ctl u_line (
        .clk                   (SYS_CLK),
        .rst_n                 (rst_n),
        .loop_mode             (setup_reg[SU_LOOP_HI:SU_LOOP_LO]),
        .so_ctrl               (setup_reg[SU_SOCTL_HI:SU_SOCTL_LO]),
        .default_val           (setup_reg[SU_DEFVAL]),
        .trst                  (setup_reg[SU_TRST]),
        .eng_shift             (ENG_SHIFT),
        .eng_macro             (ENG_MACRO),
        .eng_scan_out          (ENG_SCAN_OUT),
        .eng_mode_select       (ENG_MODE_SELECT),
        .eng_test_clock        (ENG_TEST_CLOCK),
        .scan_in_pin           (SCAN_IN_LINE),
        .scan_in_eng           (SCAN_IN_TO_ENGINE),
        .scan_out_line         (SCAN_OUT_LINE),
        .scan_out_oe           (SCAN_OUT_LINE_OE),
        .scan_mode_select_line (SCAN_MODE_SELECT_LINE),
        .scan_test_clock_line  (SCAN_TEST_CLOCK_LINE),
        .test_reset_out_a_n    (TEST_RESET_OUT_A_N),
        .test_reset_out_b_n    (TEST_RESET_OUT_B_N)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_soft_pulse;
        SSI_RESET [*2];
    endsequence

    sequence s_soft_end;
        !SSI_RESET || setup_reg[SU_TRST] || (soft_cnt_reg != 2'h0);
    endsequence

    AST_DEBUG_WRITE: assert property (
        (debug && wr_status) |=> status_reg == ($past(wdata) & ST_WR_MASK))
        else $error("debug write to status not stored");

    AST_NO_WRITE: assert property (
        (!debug && wr_status) |=> status_reg == $past(status_hw))
        else $error("status written outside debug");

    AST_HALF_FULL: assert property (
        !debug |=> status_reg[ST_SI_HALF] == ($past(SI_WORD_COUNT) >= 56))
        else $error("scan-in half full flag wrong");

    AST_HALF_EMPTY: assert property (
        !debug |=> status_reg[ST_SO_HALF] == ($past(SO_WORD_COUNT) <= 56))
        else $error("scan-out half empty flag wrong");

    AST_EMPTY_FULL: assert property (
        !debug |=> status_reg[ST_SO_EMPTY] == ($past(SO_WORD_COUNT) == 0)
            && status_reg[ST_SI_FULL] == ($past(SI_WORD_COUNT) >= 2048))
        else $error("empty or full flag wrong");

    AST_SEQ_DONE: assert property (
        (!debug && SEQ_DONE) |=> status_reg[ST_SEQ])
        else $error("sequencer flag not set");

    AST_SEQ_PRIO: assert property (
        (!debug && SEQ_DONE && VEC_DONE) |=> $stable(status_reg[2:0]))
        else $error("vector field moved under sequencer priority");

    AST_RSVD_STATUS: assert property (
        status_reg[15:13] == 3'h0 && status_reg[7:3] == 5'h00
        && status_reg[2:0] <= 3'h4)
        else $error("reserved or illegal status bits set");

    AST_SOFT_RESET: assert property (
        (wr_setup && wdata[SU_SOFT]) |=> s_soft_pulse ##1 s_soft_end)
        else $error("soft reset pulse not two cycles");

    AST_SETUP_RSVD: assert property (
        setup_rd[14:12] == 3'h0)
        else $error("setup reserved bits set");

    AST_IRQ: assert property (
        (status_reg[ST_SEQ] && INT_ENABLE[ST_SEQ]) |=> IRQ)
        else $error("interrupt not raised");

endmodule

`default_nettype wire

// file: bench/smr_host.sv
// Host processor model driving the asynchronous register strobes
`timescale 1ns/1ps
`default_nettype none
module smr_host (
    input  wire logic        clk,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [3:0]       addr,
    output logic [15:0]      wdata,
    input  wire logic [15:0] rdata
);
    // Idle bus: strobes high, address and data not meaningful
    initial begin
        {cs_n, rd_n, wr_n, addr, wdata} = {3'h7, 4'hA, 16'h5A5A};
    end
    // Write held four edges, released lines inverted, then a gap
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        {cs_n, wr_n, addr, wdata} = {2'h0, a, d};
        repeat (4) @(posedge clk);
        #1 {cs_n, wr_n, addr, wdata} = {2'h3, ~a, ~d};
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Read data stands from the third edge, taken at the fourth
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        {cs_n, rd_n, addr} = {2'h0, a};
        repeat (4) @(posedge clk);
        d = rdata;
        #1 {cs_n, rd_n, addr} = {2'h3, ~a};
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the status and setup register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import smr_pkg::*;
    logic        clk, arst_n, irq, serial_scan_interface, ta_n, ms, oe;
    logic        cs_n, rd_n, wr_n, s_s, s_d, v_d;
    logic [3:0]  addr;
    logic [15:0] wd, rdat, ien, rv;
    logic [11:0] so_c, si_c;
    logic [2:0]  v_n;
    logic [5:0]  eng, fld;
    logic        tb_n, tck, so, sie, doe, oe_seen;
    int          error_cnt, samples_checked, ssi_cnt;
    smr_host i_smr_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .wdata(wd), .rdata(rdat));
    smr_regs i_smr_regs (.SYS_CLK(clk), .ARST_N(arst_n),
        .HOST_CS_N(cs_n), .HOST_RD_N(rd_n), .HOST_WR_N(wr_n),
        .HOST_ADDR(addr), .HOST_DATA_IN(wd), .HOST_DATA_OUT(rdat),
        .HOST_DATA_OE(doe), .INT_ENABLE(ien), .SO_WORD_COUNT(so_c),
        .SI_WORD_COUNT(si_c), .SEQ_START(s_s), .SEQ_DONE(s_d),
        .VEC_DONE(v_d), .VEC_NUM(v_n), .ENG_SHIFT(eng[0]),
        .ENG_MACRO(eng[1]), .ENG_SCAN_OUT(eng[2]),
        .ENG_MODE_SELECT(eng[3]), .ENG_TEST_CLOCK(eng[4]),
        .SCAN_IN_LINE(eng[5]), .IRQ(irq), .WIDTH_MODE(fld[5]),
        .SYNC_BIT_LENGTH(fld[4:2]), .BRIDGE_SUPPORT(fld[1]),
        .DEBUG_MODE(fld[0]), .SSI_RESET(serial_scan_interface),
        .SCAN_IN_TO_ENGINE(sie), .SCAN_OUT_LINE(so),
        .SCAN_OUT_LINE_OE(oe), .SCAN_MODE_SELECT_LINE(ms),
        .SCAN_TEST_CLOCK_LINE(tck), .TEST_RESET_OUT_A_N(ta_n),
        .TEST_RESET_OUT_B_N(tb_n));
    // Clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Counts cycles of scan logic reset
    always @(posedge clk) ssi_cnt += serial_scan_interface;
    // Last data enable seen while the read strobe was low
    always @(posedge clk) if (!rd_n) oe_seen = doe;
    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        i_smr_host.rd(a, rv);
        chk("register", e, rv);
        chk("data oe", 16'h0002, {oe_seen, doe});
    endtask
    // One event pulse: start, done, vector done, vector number
    task automatic ev(input logic [5:0] v);
        {s_s, s_d, v_d, v_n} = v;
        @(posedge clk);
        #1 {s_s, s_d, v_d, v_n} = 6'h00;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_setup();
        i_smr_host.wr(OFF_SETUP, 16'hFFFF);
        rchk(OFF_SETUP, 16'h8FFB);
        chk("fields", 16'h003F, {10'h0, fld});
        chk("lines", 16'h000C, {ta_n, tb_n, serial_scan_interface, ms, oe, tck});
        i_smr_host.wr(OFF_SETUP, 16'h0000);
        chk("trst", 16'h0006, {ta_n, tb_n, serial_scan_interface});
        ssi_cnt = 0;
        i_smr_host.wr(OFF_SETUP, 16'h0004);
        chk("soft", 16'h0002, ssi_cnt[15:0]);
    endtask
    task automatic t_lines();
        eng = 6'h08;
        i_smr_host.wr(OFF_SETUP, 16'h0441);
        chk("loop so", 16'h0007, {so, sie, oe});
        i_smr_host.wr(OFF_SETUP, 16'h0402);
        chk("loop ms", 16'h0003, {so, sie, oe});
        eng = 6'h22;
        i_smr_host.wr(OFF_SETUP, 16'h0C40);
        chk("macro hiz", 16'h0006, {so, sie, oe});
        eng = 6'h00;
    endtask
    task automatic t_flags();
        logic [11:0] so[4] = '{12'h038, 12'h039, 12'h039, 12'h039};
        logic [11:0] si[4] = '{12'h037, 12'h038, 12'h800, 12'h000};
        logic [15:0] ex[4] = '{16'h1000, 16'h0200, 16'h0600, 16'h0000};
        for (int k = 0; k < 4; k++) begin
            {so_c, si_c} = {so[k], si[k]};
            rchk(OFF_STATUS, ex[k]);
        end
    endtask
    task automatic t_seq();
        ev(6'h20);
        ev(6'h0B);
        rchk(OFF_STATUS, 16'h0003);
        ev(6'h10);
        rchk(OFF_STATUS, 16'h0103);
        ev(6'h0A);
        rchk(OFF_STATUS, 16'h0103);
        ien = 16'h0100;
        repeat (3) @(posedge clk);
        #1;
        chk("irq", 16'h0001, {15'h0, irq});
        ien = 16'h0000;
    endtask
    task automatic t_debug();
        i_smr_host.wr(OFF_STATUS, 16'h0000);
        rchk(OFF_STATUS, 16'h0103);
        i_smr_host.wr(OFF_SETUP, 16'h0020);
        i_smr_host.wr(OFF_STATUS, 16'hFFFC);
        rchk(OFF_STATUS, 16'h1F04);
        rchk(4'h5, 16'h0000);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
    initial begin
        {arst_n, s_s, s_d, v_d, v_n, eng, ien} = '0;
        {so_c, si_c} = 24'h0;
        repeat (20) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rchk(OFF_STATUS, 16'h1800);
        rchk(OFF_SETUP, 16'h0043);
        t_setup();
        t_lines();
        t_flags();
        t_seq();
        t_debug();
        finish_test();
    end
endmodule
`default_nettype wire
